// File: shared/psa_consts.svh
// constants of the program-flow and indirect-addressing block
// How it works
// - counter is 13 bits; low byte readable and writable, upper five bits hidden
// - only a low-byte write copies the whole holding register into the upper counter bits; call and jump copy bits 4..3
// - low-byte write loads counter from result low and holding bits 4..0 high
// - call and jump take 11 opcode bits plus holding bits 4..3 as page
// - page bits do not reach program fetch on this small device
// - eight-entry 13-bit return stack with hidden pointer, outside program and data space
// - call and interrupt acknowledge push the whole counter
// - returns pop into the counter; holding register untouched by push and pop
// - pushes wrap; ninth push overwrites first stored entry
// - pops wrap; ninth pop returns same value as first
// - no overflow or underflow detection or status
// - virtual register access reaches register addressed by pointer
// - indirect read of the virtual register itself returns zero
// - indirect write of the virtual register itself stores nothing
// - effective indirect address is bank bit above 8-bit pointer; bank bit forced to zero unless USE_BANK is set
// - counter upper bits never copied back into holding register
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH

`define PSA_PC_W         13
`define PSA_BYTE_W       8
`define PSA_HOLD_W       5
`define PSA_OPADDR_W     11
`define PSA_EFF_W        9
`define PSA_STACK_DEPTH  8

`define PSA_OFS_VIRT     8'h00
`define PSA_OFS_LOW      8'h02
`define PSA_OFS_PTR      8'h04
`define PSA_OFS_HOLD     8'h0A

`define PSA_PAGE_HI      4
`define PSA_PAGE_LO      3

`define PSA_RST_PC       13'h0000
`define PSA_RST_HOLD     5'h00
`define PSA_RST_PTR      8'h00
`define PSA_SELF_RDATA   8'h00
`define PSA_PC_STEP      13'h0001
`define PSA_INT_VECTOR   13'h0004

`endif

// File: shared/psa_pkg.sv
// types of the program-flow and indirect-addressing block
`include "psa_consts.svh"
package psa_pkg;

    typedef enum logic [2:0] {
        PSA_SRC_KEEP = 3'b000,
        PSA_SRC_STEP = 3'b001,
        PSA_SRC_LOW  = 3'b010,
        PSA_SRC_JUMP = 3'b011,
        PSA_SRC_CALL = 3'b100,
        PSA_SRC_RET  = 3'b101,
        PSA_SRC_INT  = 3'b110
    } psa_pc_src_t;

    typedef enum logic [2:0] {
        PSA_SEL_MEM  = 3'b000,
        PSA_SEL_LOW  = 3'b001,
        PSA_SEL_PTR  = 3'b010,
        PSA_SEL_HOLD = 3'b011,
        PSA_SEL_NONE = 3'b100
    } psa_sel_t;

    typedef struct packed {
        logic                       fetchStep;
        logic                       callOp;
        logic                       jumpOp;
        logic                       returnOp;
        logic                       intAck;
        logic [`PSA_OPADDR_W-1:0]   opAddr;
    } psa_flow_t;

    typedef struct packed {
        logic [`PSA_BYTE_W-1:0]     addr;
        logic [`PSA_BYTE_W-1:0]     wrData;
        logic                       wrStrobe;
        logic                       rdStrobe;
    } psa_reg_req_t;

    typedef struct packed {
        logic [`PSA_EFF_W-1:0]      addr;
        logic [`PSA_BYTE_W-1:0]     wrData;
        logic                       write;
        logic                       read;
    } psa_mem_req_t;

endpackage : psa_pkg

// File: src/psa_stack.sv
// circular return-address stack
`timescale 1ns/1ps
module psa_stack
    import psa_pkg::*;
#(
    parameter int DEPTH = `PSA_STACK_DEPTH,
    parameter int WIDTH = `PSA_PC_W
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] pushData,
    output logic      [WIDTH-1:0] topData
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("psa_stack: depth must be a power of two, width positive");
        end
    end

    // ****************************************
    // storage and pointer
    // ****************************************
    logic [WIDTH-1:0] entry [DEPTH];
    logic [PW-1:0]    ptr;
    logic [PW-1:0]    next_ptr;

    // pointer wraps freely, no overflow or underflow flag
    always_comb begin
        next_ptr = ptr;
        if (push) begin
            next_ptr = ptr + PW'(1);
        end else if (pop) begin
            next_ptr = ptr - PW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    // contents are not cleared by reset
    always_ff @(posedge sys_clk) begin
        if (push) begin
            entry[ptr] <= pushData;
        end
    end

    assign topData = entry[ptr - PW'(1)];

    // ****************************************
    // checks
    // ****************************************
    a_push_wrap_ptr: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (push && !pop)[*8] |=> ptr == $past(ptr, 8))
        else $error("pointer did not wrap after eight pushes");

    a_pop_wrap_ptr: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (pop && !push)[*8] |=> ptr == $past(ptr, 8))
        else $error("pointer did not wrap after eight pops");

endmodule : psa_stack

// File: src/psa_core.sv
// program counter, return stack and indirect addressing of the core
`timescale 1ns/1ps
module psa_core
    import psa_pkg::*;
#(
    parameter int                  FETCH_W    = 10,
    parameter logic                USE_BANK   = 1'b0,
    parameter logic [`PSA_PC_W-1:0] INT_VECTOR = `PSA_INT_VECTOR
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire psa_flow_t              flowIn,
    input  wire logic                   bankBit,
    input  wire psa_reg_req_t           regReq,
    output logic      [`PSA_BYTE_W-1:0] regRdData,
    output psa_mem_req_t                memReq,
    input  wire logic [`PSA_BYTE_W-1:0] memRdData,
    output logic      [`PSA_PC_W-1:0]   programCounter,
    output logic      [FETCH_W-1:0]     fetchAddr
);

    initial begin
        if (FETCH_W < 1 || FETCH_W > `PSA_PC_W) begin
            $error("psa_core: fetch width must lie between 1 and the counter width");
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    // effective target of a file access, direct or through the pointer
    function automatic psa_sel_t decodeTarget(
        input logic [`PSA_EFF_W-1:0] eff,
        input logic                  isSelf
    );
        psa_sel_t sel;
        sel = PSA_SEL_MEM;
        if (isSelf) begin
            sel = PSA_SEL_NONE;
        end else if (eff[`PSA_EFF_W-1] == 1'b0) begin
            case (eff[`PSA_BYTE_W-1:0])
                `PSA_OFS_LOW:  sel = PSA_SEL_LOW;
                `PSA_OFS_PTR:  sel = PSA_SEL_PTR;
                `PSA_OFS_HOLD: sel = PSA_SEL_HOLD;
                `PSA_OFS_VIRT: sel = PSA_SEL_NONE;
                default:       sel = PSA_SEL_MEM;
            endcase
        end
        return sel;
    endfunction : decodeTarget

    logic [`PSA_PC_W-1:0]   pc;
    logic [`PSA_HOLD_W-1:0] hold;
    logic [`PSA_BYTE_W-1:0] ptr;
    logic [`PSA_PC_W-1:0]   stackTop;

    logic                   isIndirect;
    logic                   isSelf;
    logic [`PSA_EFF_W-1:0]  effAddr;
    psa_sel_t               target;
    logic                   lowWrite;

    always_comb begin
        isIndirect = (regReq.addr == `PSA_OFS_VIRT);
        isSelf     = isIndirect && (ptr == `PSA_OFS_VIRT);
        if (isIndirect) begin
            effAddr = {bankBit & USE_BANK, ptr};
        end else begin
            effAddr = {1'b0, regReq.addr};
        end
        target   = decodeTarget(effAddr, isSelf);
        lowWrite = regReq.wrStrobe && (target == PSA_SEL_LOW);
    end

    // ****************************************
    // data memory forwarding
    // ****************************************
    always_comb begin
        memReq.addr   = effAddr;
        memReq.wrData = regReq.wrData;
        memReq.write  = regReq.wrStrobe && (target == PSA_SEL_MEM);
        memReq.read   = regReq.rdStrobe && (target == PSA_SEL_MEM);
    end

    // ****************************************
    // counter source selection
    // ****************************************
    psa_pc_src_t pcSrc;
    logic        stackPush;
    logic        stackPop;

    always_comb begin
        pcSrc = PSA_SRC_KEEP;
        if (flowIn.intAck) begin
            pcSrc = PSA_SRC_INT;
        end else if (flowIn.returnOp) begin
            pcSrc = PSA_SRC_RET;
        end else if (flowIn.callOp) begin
            pcSrc = PSA_SRC_CALL;
        end else if (flowIn.jumpOp) begin
            pcSrc = PSA_SRC_JUMP;
        end else if (lowWrite) begin
            pcSrc = PSA_SRC_LOW;
        end else if (flowIn.fetchStep) begin
            pcSrc = PSA_SRC_STEP;
        end
        stackPush = (pcSrc == PSA_SRC_INT) || (pcSrc == PSA_SRC_CALL);
        stackPop  = (pcSrc == PSA_SRC_RET);
    end

    // ****************************************
    // program counter
    // ****************************************
    logic [`PSA_PC_W-1:0] next_pc;

    always_comb begin
        case (pcSrc)
            PSA_SRC_STEP: next_pc = pc + `PSA_PC_STEP;
            PSA_SRC_LOW:  next_pc = {hold, regReq.wrData};
            PSA_SRC_JUMP: next_pc = {hold[`PSA_PAGE_HI:`PSA_PAGE_LO], flowIn.opAddr};
            PSA_SRC_CALL: next_pc = {hold[`PSA_PAGE_HI:`PSA_PAGE_LO], flowIn.opAddr};
            PSA_SRC_RET:  next_pc = stackTop;
            PSA_SRC_INT:  next_pc = INT_VECTOR;
            PSA_SRC_KEEP: next_pc = pc;
            default:      next_pc = pc;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc <= `PSA_RST_PC;
        end else begin
            pc <= next_pc;
        end
    end

    assign programCounter = pc;
    // page bits sit in the counter but the small array sees only the low bits
    assign fetchAddr      = pc[FETCH_W-1:0];

    // ****************************************
    // holding register and pointer
    // ****************************************
    logic [`PSA_HOLD_W-1:0] next_hold;
    logic [`PSA_BYTE_W-1:0] next_ptr;

    // holding register only ever written by software, never from the counter
    always_comb begin
        next_hold = hold;
        next_ptr  = ptr;
        if (regReq.wrStrobe && target == PSA_SEL_HOLD) begin
            next_hold = regReq.wrData[`PSA_HOLD_W-1:0];
        end
        if (regReq.wrStrobe && target == PSA_SEL_PTR) begin
            next_ptr = regReq.wrData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold <= `PSA_RST_HOLD;
            ptr  <= `PSA_RST_PTR;
        end else begin
            hold <= next_hold;
            ptr  <= next_ptr;
        end
    end

    // ****************************************
    // return stack
    // ****************************************
    psa_stack #(
        .DEPTH (`PSA_STACK_DEPTH),
        .WIDTH (`PSA_PC_W)
    ) u_stack (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .push     (stackPush),
        .pop      (stackPop),
        .pushData (pc),
        .topData  (stackTop)
    );

    // ****************************************
    // read data
    // ****************************************
    psa_sel_t               rdSel;
    psa_sel_t               next_rdSel;
    logic [`PSA_BYTE_W-1:0] rdOwn;
    logic [`PSA_BYTE_W-1:0] next_rdOwn;

    always_comb begin
        next_rdSel = rdSel;
        next_rdOwn = rdOwn;
        if (regReq.rdStrobe) begin
            next_rdSel = target;
            case (target)
                PSA_SEL_LOW:  next_rdOwn = pc[`PSA_BYTE_W-1:0];
                PSA_SEL_PTR:  next_rdOwn = ptr;
                PSA_SEL_HOLD: next_rdOwn = {{(`PSA_BYTE_W-`PSA_HOLD_W){1'b0}}, hold};
                PSA_SEL_NONE: next_rdOwn = `PSA_SELF_RDATA;
                default:      next_rdOwn = `PSA_SELF_RDATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdSel <= PSA_SEL_NONE;
            rdOwn <= `PSA_SELF_RDATA;
        end else begin
            rdSel <= next_rdSel;
            rdOwn <= next_rdOwn;
        end
    end

    assign regRdData = (rdSel == PSA_SEL_MEM) ? memRdData : rdOwn;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_step_only;
        flowIn.fetchStep && !flowIn.intAck && !flowIn.returnOp && !flowIn.callOp
            && !flowIn.jumpOp && !lowWrite;
    endsequence

    sequence s_call_only;
        flowIn.callOp && !flowIn.intAck && !flowIn.returnOp;
    endsequence

    sequence s_return_only;
        flowIn.returnOp && !flowIn.intAck;
    endsequence

    sequence s_self_read;
        regReq.rdStrobe && regReq.addr == `PSA_OFS_VIRT && ptr == `PSA_OFS_VIRT;
    endsequence

    a_step_increment: assert property (
        s_step_only |=> programCounter == $past(programCounter) + `PSA_PC_STEP)
        else $error("counter did not step by one");

    a_low_byte_load: assert property (
        lowWrite && !flowIn.intAck && !flowIn.returnOp && !flowIn.callOp && !flowIn.jumpOp
        |=> programCounter == {$past(hold), $past(regReq.wrData)})
        else $error("low byte write loaded a wrong counter");

    a_call_page_load: assert property (
        s_call_only |=> programCounter[`PSA_OPADDR_W-1:0] == $past(flowIn.opAddr)
            && programCounter[`PSA_PC_W-1:`PSA_OPADDR_W]
               == $past(hold[`PSA_PAGE_HI:`PSA_PAGE_LO]))
        else $error("call did not load page and address");

    a_call_push_top: assert property (
        s_call_only |=> stackTop == $past(programCounter))
        else $error("call did not push the counter");

    a_return_pops: assert property (
        s_return_only |=> programCounter == $past(stackTop))
        else $error("return did not pop the counter");

    a_hold_kept: assert property (
        !(regReq.wrStrobe && target == PSA_SEL_HOLD) |=> hold == $past(hold))
        else $error("holding register changed without a write");

    a_self_read_zero: assert property (
        s_self_read |=> regRdData == `PSA_SELF_RDATA)
        else $error("self indirect read not zero");

    a_self_write_none: assert property (
        regReq.wrStrobe && isSelf |-> !memReq.write ##1 ptr == $past(ptr)
            && hold == $past(hold))
        else $error("self indirect write stored data");

    a_indirect_route: assert property (
        regReq.rdStrobe && isIndirect && target == PSA_SEL_MEM
        |-> memReq.read && memReq.addr[`PSA_BYTE_W-1:0] == ptr)
        else $error("indirect access not routed through pointer");

    a_int_vector: assert property (
        flowIn.intAck |=> programCounter == INT_VECTOR && stackTop == $past(programCounter))
        else $error("interrupt acknowledge did not vector and push");

endmodule : psa_core

// File: verif/psa_mem_model.sv
// data memory model serving the core's forwarded and indirect accesses
`timescale 1ns/1ps
`include "psa_consts.svh"
module psa_mem_model
    import psa_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire psa_mem_req_t           memReq,
    output logic      [`PSA_BYTE_W-1:0] memRdData
);
    logic [`PSA_BYTE_W-1:0] store [0:(1<<`PSA_EFF_W)-1];

    // ************************************
    // storage and one-cycle read answer
    // ************************************
    // outside the answer cycle the data line toggles, never holding stale data
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            memRdData <= 8'h5A;
        end else begin
            if (memReq.write) begin
                store[memReq.addr] <= memReq.wrData;
            end
            if (memReq.read) begin
                memRdData <= store[memReq.addr];
            end else begin
                memRdData <= ~memRdData;
            end
        end
    end
endmodule : psa_mem_model

// File: verif/tb.sv
// self-checking bench of the program counter, return stack and indirect access
`timescale 1ns/1ps
`include "psa_consts.svh"
module tb
    import psa_pkg::*;
;
    localparam logic [4:0] STEP = 5'b10000;
    localparam logic [4:0] CALL = 5'b01000;
    localparam logic [4:0] JUMP = 5'b00100;
    localparam logic [4:0] RET  = 5'b00010;
    localparam logic [4:0] IACK = 5'b00001;

    logic                   sys_clk = 1'b0;
    logic                   rst_b   = 1'b0;
    logic                   bankBit = 1'b1;
    psa_flow_t              flowIn  = '0;
    psa_reg_req_t           regReq  = '0;
    logic [`PSA_BYTE_W-1:0] regRdData;
    psa_mem_req_t           memReq;
    psa_mem_req_t           lastMem;
    logic [`PSA_BYTE_W-1:0] memRdData;
    logic [`PSA_PC_W-1:0]   programCounter;
    logic [9:0]             fetchAddr;
    int                     badCount = 0;
    int                     checked  = 0;
    int                     cycles   = 0;

    always #2.5 sys_clk = ~sys_clk;

    psa_core #(.FETCH_W(10), .USE_BANK(1'b0), .INT_VECTOR(`PSA_INT_VECTOR)) DUT (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .flowIn         (flowIn),
        .bankBit        (bankBit),
        .regReq         (regReq),
        .regRdData      (regRdData),
        .memReq         (memReq),
        .memRdData      (memRdData),
        .programCounter (programCounter),
        .fetchAddr      (fetchAddr)
    );

    psa_mem_model mem (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .memReq    (memReq),
        .memRdData (memRdData)
    );

    // ************************************
    // report and compare
    // ************************************
    task automatic stopTest();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stopTest

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            badCount++;
        end
    endtask : cmp8

    task automatic cmp13(input string what, input logic [12:0] exp, input logic [12:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            badCount++;
        end
    endtask : cmp13

    // ************************************
    // register port and flow pulses
    // ************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
        @(negedge sys_clk);
        lastMem = memReq;
        @(posedge sys_clk);
        regReq.wrStrobe <= 1'b0;
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        regReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
        @(posedge sys_clk);
        regReq.rdStrobe <= 1'b0;
        @(negedge sys_clk);
        cmp8(what, exp, regRdData);
    endtask : rdChk

    task automatic pulse(input logic [4:0] kinds, input logic [10:0] a);
        @(posedge sys_clk);
        flowIn <= {kinds, a};
        @(posedge sys_clk);
        flowIn <= '0;
        @(negedge sys_clk);
    endtask : pulse

    // ************************************
    // hang guard
    // ************************************
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            $display("Error timeout expected end seen hang");
            badCount++;
            stopTest();
        end
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        cmp13("counter reset", 13'h0000, programCounter);
        cmp13("fetch reset", 13'h0000, {3'b000, fetchAddr});
        rdChk(`PSA_OFS_HOLD, 8'h00, "holding reset");
        rdChk(`PSA_OFS_PTR, 8'h00, "pointer reset");
        wr(`PSA_OFS_HOLD, 8'hFF);
        rdChk(`PSA_OFS_HOLD, 8'h1F, "holding width");
        wr(`PSA_OFS_LOW, 8'h34);
        @(negedge sys_clk);
        cmp13("low byte load", 13'h1F34, programCounter);
        cmp13("fetch page ignored", 13'h0334, {3'b000, fetchAddr});
        cmp8("low write not forwarded", 8'h00, {7'h00, lastMem.write});
        rdChk(`PSA_OFS_LOW, 8'h34, "low byte read");
        pulse(JUMP, 11'h555);
        cmp13("jump target", 13'h1D55, programCounter);
        cmp13("jump fetch", 13'h0155, {3'b000, fetchAddr});
        rdChk(`PSA_OFS_HOLD, 8'h1F, "holding after jump");
        wr(`PSA_OFS_LOW, 8'hFF);
        pulse(STEP, 11'h000);
        cmp13("step wrap", 13'h0000, programCounter);
        pulse(STEP, 11'h000);
        cmp13("step", 13'h0001, programCounter);
        wr(`PSA_OFS_HOLD, 8'h18);
        for (int k = 0; k < 9; k++) begin
            pulse(CALL, 11'h100 + 11'(k));
            cmp13("call target", 13'h1900 + 13'(k), programCounter);
        end
        for (int k = 0; k < 9; k++) begin
            pulse(RET, 11'h000);
            cmp13("pop value", (k == 8) ? 13'h1907 : 13'h1907 - 13'(k), programCounter);
        end
        rdChk(`PSA_OFS_HOLD, 8'h18, "holding after stack");
        pulse(IACK, 11'h000);
        cmp13("interrupt vector", `PSA_INT_VECTOR, programCounter);
        pulse(RET, 11'h000);
        cmp13("interrupt return", 13'h1907, programCounter);
        // back-to-back bursts so the wrap checks see eight pushes and pops in a row
        @(posedge sys_clk);
        flowIn <= {CALL, 11'h200};
        repeat (8) @(posedge sys_clk);
        cmp13("burst call target", 13'h1A00, programCounter);
        flowIn <= {RET, 11'h000};
        repeat (8) @(posedge sys_clk);
        flowIn <= '0;
        @(negedge sys_clk);
        cmp13("burst return", 13'h1907, programCounter);
        wr(`PSA_OFS_PTR, 8'h05);
        wr(`PSA_OFS_VIRT, 8'hA5);
        cmp13("indirect address", 13'h0005, {4'h0, lastMem.addr});
        cmp8("indirect write", 8'h01, {7'h00, lastMem.write});
        wr(`PSA_OFS_PTR, 8'h06);
        wr(`PSA_OFS_VIRT, 8'h0A);
        wr(`PSA_OFS_PTR, 8'h05);
        rdChk(`PSA_OFS_VIRT, 8'hA5, "indirect read first");
        wr(`PSA_OFS_PTR, 8'h06);
        rdChk(`PSA_OFS_VIRT, 8'h0A, "indirect read second");
        wr(8'h20, 8'h3C);
        wr(`PSA_OFS_PTR, 8'h20);
        rdChk(`PSA_OFS_VIRT, 8'h3C, "indirect to direct");
        wr(`PSA_OFS_PTR, 8'h00);
        wr(`PSA_OFS_VIRT, 8'h77);
        cmp8("self write dropped", 8'h00, {7'h00, lastMem.write});
        rdChk(`PSA_OFS_VIRT, 8'h00, "self read");
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        cmp13("counter second reset", 13'h0000, programCounter);
        rdChk(`PSA_OFS_HOLD, 8'h00, "holding second reset");
        stopTest();
    end
endmodule : tb
